// >>> logic/mode_word_regs.svh
// Behaviour
// R01 - Bit 0 forces DC voltage control mode
// R02 - Bit 1 forces island mode
// R03 - Bit 2 forces droop control mode
// R04 - Bit 3 forces droop with base load
// R05 - Bit 4 forces fixed power mode
// R06 - Bit 5 forces DC-link current/power mode
// R07 - Bit 6 forces AC current/power mode
// R08 - Highest priority forced mode wins
// R09 - Bit 7 raises frequency reference
// R10 - Bit 8 lowers frequency reference
// R11 - Bit 9 resets frequency reference
// R12 - Bit 13 picks nominal or measured frequency
// R13 - Bits 10-12 raise, lower, reset voltage
// R14 - Bit 14 picks nominal or measured voltage
// R15 - Custom status bits pick any source bit
// R16 - Default bits 0-4 copy mode status
// R17 - Default bits 5-7 copy app word two
// R18 - Panel local button toggles on rising edge
// R19 - Panel stop works from every place
// R20 - Stop held 3 s issues switch-off; code issues it only while breaker_by_app_i is high
// R21 - Place change stops unless continue enabled
// R22 - Low level start counts as stop
// R23 - Bit 15 ignored, unconfigured bits zero
// R24 - Up and down together hold; reset wins
`ifndef MODE_WORD_REGS_SVH
`define MODE_WORD_REGS_SVH
`define FW_DCV_BIT       0
`define FW_ISL_BIT       1
`define FW_DRP_BIT       2
`define FW_DBL_BIT       3
`define FW_FPW_BIT       4
`define FW_DCI_BIT       5
`define FW_ACI_BIT       6
`define FW_FUP_BIT       7
`define FW_FDN_BIT       8
`define FW_FRS_BIT       9
`define FW_VUP_BIT       10
`define FW_VDN_BIT       11
`define FW_VRS_BIT       12
`define FW_FSEL_BIT      13
`define FW_VSEL_BIT      14
`define FORCE_WORD_RESET 16'h0000
`define SEL_UNUSED       7'h7f
`define HOLD_TIME_MS     3000
`define CLK_MHZ          100
`define HOLD_CYCLES      (`HOLD_TIME_MS * 1000 * `CLK_MHZ)
`endif

// >>> logic/mode_word_pkg.sv
package mode_word_pkg;
  typedef enum logic [2:0] {
    MODE_NONE = 3'h0,
    MODE_FPW  = 3'h1,
    MODE_DBL  = 3'h2,
    MODE_DRP  = 3'h3,
    MODE_ISL  = 3'h4,
    MODE_DCV  = 3'h5,
    MODE_DCI  = 3'h6,
    MODE_ACI  = 3'h7
  } mode_type;
  typedef enum logic [1:0] {
    PLACE_IO    = 2'h0,
    PLACE_FBUS  = 2'h1,
    PLACE_LOCAL = 2'h2,
    PLACE_PC    = 2'h3
  } place_type;
  typedef enum logic [1:0] {
    START_PULSE = 2'h0,
    START_LEVEL = 2'h1,
    START_EDGE  = 2'h2
  } start_mode_type;
  typedef enum logic [1:0] {
    RUN_IDLE = 2'b00,
    RUN_ON   = 2'b01
  } run_state_type;
endpackage

// >>> logic/reference_stepper.sv
`timescale 1ns/1ns
module reference_stepper #(
  parameter int WIDTH = 16
) (
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  input  wire logic             step_en_i,
  input  wire logic             up_i,
  input  wire logic             down_i,
  input  wire logic             reset_i,
  input  wire logic             use_actual_i,
  input  wire logic [WIDTH-1:0] nominal_i,
  input  wire logic [WIDTH-1:0] actual_i,
  input  wire logic [WIDTH-1:0] step_i,
  output logic      [WIDTH-1:0] ref_o
);
  logic [WIDTH-1:0] ref_reg;
  logic [WIDTH-1:0] ref_next;
  wire  [WIDTH-1:0] reset_value = use_actual_i ? actual_i : nominal_i;
  wire              do_up       = step_en_i && up_i && !down_i;
  wire              do_down     = step_en_i && down_i && !up_i;

  always_comb begin
    ref_next = ref_reg;
    if (reset_i) begin
      ref_next = reset_value;  // [R24]
    end else if (do_up) begin
      ref_next = ref_reg + step_i;
    end else if (do_down) begin
      ref_next = ref_reg - step_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ref_reg <= '0;
    end else begin
      ref_reg <= ref_next;
    end
  end

  assign ref_o = ref_reg;

  property p_reset_wins;
    @(posedge clock_i) disable iff (!rst_n_i)
      reset_i |=> ref_reg == $past(reset_value);
  endproperty
  a_reset_wins: assert property (p_reset_wins) else $error("reset value not loaded"); // [R24]

  property p_both_hold;
    @(posedge clock_i) disable iff (!rst_n_i)
      (up_i && down_i && !reset_i) |=> $stable(ref_reg);
  endproperty
  a_both_hold: assert property (p_both_hold) else $error("reference moved on conflict"); // [R24]
endmodule // reference_stepper

// >>> logic/status_bit_picker.sv
`timescale 1ns/1ns
`include "mode_word_regs.svh"
module status_bit_picker (
  input  wire logic [63:0] sources_i,
  input  wire logic [6:0]  select_i,
  output logic             bit_o
);
  // Select 0..63 picks a source bit, any higher code reads zero
  wire in_range = !select_i[6];
  assign bit_o = in_range ? sources_i[select_i[5:0]] : 1'b0;  // [R15] [R23]
endmodule // status_bit_picker

// >>> logic/mode_word_decoder.sv
`timescale 1ns/1ns
`include "mode_word_regs.svh"
module mode_word_decoder #(
  parameter int        REF_W       = 16,
  parameter int        HOLD_CYCLES = `HOLD_CYCLES,
  parameter int        STEP_DIV    = 100000,
  parameter logic [6:0] SEL_DEF [16] = '{
    7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h21, 7'h22, 7'h2a,
    `SEL_UNUSED, `SEL_UNUSED, `SEL_UNUSED, `SEL_UNUSED,
    `SEL_UNUSED, `SEL_UNUSED, `SEL_UNUSED, `SEL_UNUSED}
) (
  input  wire logic                   clock_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   force_wr_i,
  input  wire logic [15:0]            force_data_i,
  output logic      [15:0]            force_word_o,
  input  wire logic                   sel_wr_i,
  input  wire logic [3:0]             sel_index_i,
  input  wire logic [6:0]             sel_data_i,
  input  wire logic [15:0]            mode_status_i,
  input  wire logic [15:0]            app_status1_i,
  input  wire logic [15:0]            app_status2_i,
  input  wire logic [15:0]            limit_status_i,
  output logic      [15:0]            status_word_o,
  output logic      [6:0]             forced_mask_o,
  output mode_word_pkg::mode_type     mode_o,
  input  wire logic [REF_W-1:0]       freq_nominal_i,
  input  wire logic [REF_W-1:0]       freq_actual_i,
  input  wire logic [REF_W-1:0]       volt_nominal_i,
  input  wire logic [REF_W-1:0]       volt_actual_i,
  input  wire logic [REF_W-1:0]       ref_step_i,
  output logic      [REF_W-1:0]       freq_ref_o,
  output logic      [REF_W-1:0]       volt_ref_o,
  input  wire logic                   panel_remloc_i,
  input  wire logic                   panel_start_i,
  input  wire logic                   panel_stop_i,
  input  wire mode_word_pkg::place_type place_req_i,
  input  wire logic [3:0]             continue_en_i,
  input  wire mode_word_pkg::start_mode_type new_start_mode_i,
  input  wire logic                   new_start_level_i,
  input  wire logic                   new_stop_req_i,
  input  wire logic                   running_i,
  input  wire logic                   breaker_by_app_i,
  output logic                        local_active_o,
  output mode_word_pkg::place_type    place_o,
  output logic                        start_cmd_o,
  output logic                        stop_cmd_o,
  output logic                        switch_off_o
);
  logic [15:0]            force_reg;
  logic [6:0]             sel_reg [16];
  logic [15:0]            status_reg;
  logic [15:0]            status_next;
  logic [6:0]             mask_reg;
  mode_word_pkg::mode_type mode_reg;
  mode_word_pkg::mode_type mode_next;
  logic [REF_W-1:0]       freq_ref;
  logic [REF_W-1:0]       volt_ref;
  logic [REF_W-1:0]       freq_reg;
  logic [REF_W-1:0]       volt_reg;
  logic [31:0]            step_cnt_reg;
  logic                   step_en_reg;
  logic                   remloc_reg;
  logic                   local_reg;
  mode_word_pkg::place_type place_reg;
  mode_word_pkg::place_type place_next;
  logic [31:0]            hold_cnt_reg;
  logic                   off_done_reg;
  logic                   start_reg;
  logic                   stop_reg;
  logic                   off_reg;

  // Force word; bit 15 stored but never used
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      force_reg <= `FORCE_WORD_RESET;
    end else if (force_wr_i) begin
      force_reg <= force_data_i;  // [R23]
    end
  end
  assign force_word_o = force_reg;

  // Mode forcing by fixed priority
  wire [6:0] forced = {force_reg[`FW_ACI_BIT],  // [R07]
                       force_reg[`FW_DCI_BIT],  // [R06]
                       force_reg[`FW_DCV_BIT],  // [R01]
                       force_reg[`FW_ISL_BIT],  // [R02]
                       force_reg[`FW_DRP_BIT],  // [R03]
                       force_reg[`FW_DBL_BIT],  // [R04]
                       force_reg[`FW_FPW_BIT]}; // [R05]
  always_comb begin
    mode_next = mode_word_pkg::MODE_NONE;
    for (int i = 0; i < 7; i++) begin
      if (forced[i]) begin
        mode_next = mode_word_pkg::mode_type'(3'(i + 1));  // [R08]
      end
    end
  end

  // Reference step rate divider
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      step_cnt_reg <= '0;
      step_en_reg  <= 1'b0;
    end else begin
      step_en_reg  <= step_cnt_reg == 32'(STEP_DIV - 1);
      step_cnt_reg <= (step_cnt_reg == 32'(STEP_DIV - 1)) ? '0 : step_cnt_reg + 32'h1;
    end
  end

  reference_stepper #(.WIDTH(REF_W)) u_freq (
    .clock_i      (clock_i),
    .rst_n_i      (rst_n_i),
    .step_en_i    (step_en_reg),
    .up_i         (force_reg[`FW_FUP_BIT]),   // [R09]
    .down_i       (force_reg[`FW_FDN_BIT]),   // [R10]
    .reset_i      (force_reg[`FW_FRS_BIT]),   // [R11]
    .use_actual_i (force_reg[`FW_FSEL_BIT]),  // [R12]
    .nominal_i    (freq_nominal_i),
    .actual_i     (freq_actual_i),
    .step_i       (ref_step_i),
    .ref_o        (freq_ref)
  );
  reference_stepper #(.WIDTH(REF_W)) u_volt (
    .clock_i      (clock_i),
    .rst_n_i      (rst_n_i),
    .step_en_i    (step_en_reg),
    .up_i         (force_reg[`FW_VUP_BIT]),   // [R13]
    .down_i       (force_reg[`FW_VDN_BIT]),
    .reset_i      (force_reg[`FW_VRS_BIT]),
    .use_actual_i (force_reg[`FW_VSEL_BIT]),  // [R14]
    .nominal_i    (volt_nominal_i),
    .actual_i     (volt_actual_i),
    .step_i       (ref_step_i),
    .ref_o        (volt_ref)
  );

  // Custom status word selection
  wire [63:0] sources = {limit_status_i, app_status2_i, app_status1_i, mode_status_i};
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 16; i++) begin
        sel_reg[i] <= SEL_DEF[i];  // [R16] [R17]
      end
    end else if (sel_wr_i) begin
      sel_reg[sel_index_i] <= sel_data_i;  // [R15]
    end
  end
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_pick
      status_bit_picker u_pick (
        .sources_i (sources),
        .select_i  (sel_reg[g]),
        .bit_o     (status_next[g])
      );
    end
  endgenerate

  // Control place and panel handling
  wire remloc_rise = panel_remloc_i && !remloc_reg;
  wire local_next  = remloc_rise ? !local_reg : local_reg;  // [R18]
  assign place_next = local_next ? mode_word_pkg::PLACE_LOCAL : place_req_i;
  wire place_change = place_next != place_reg;
  wire level_start  = new_start_mode_i != mode_word_pkg::START_PULSE;
  wire new_stop     = new_stop_req_i || (level_start && !new_start_level_i);  // [R22]
  wire keep_running = continue_en_i[place_next] && !new_stop;
  wire handover_stop = place_change && running_i && !keep_running;  // [R21]
  wire hold_full    = hold_cnt_reg == 32'(HOLD_CYCLES - 1);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      remloc_reg   <= 1'b0;
      local_reg    <= 1'b0;
      place_reg    <= mode_word_pkg::PLACE_IO;
      hold_cnt_reg <= '0;
      off_done_reg <= 1'b0;
    end else begin
      remloc_reg   <= panel_remloc_i;
      local_reg    <= local_next;
      place_reg    <= place_next;
      if (!panel_stop_i) begin
        hold_cnt_reg <= '0;
        off_done_reg <= 1'b0;
      end else if (hold_full) begin
        off_done_reg <= 1'b1;  // [R20]
      end else begin
        hold_cnt_reg <= hold_cnt_reg + 32'h1;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_reg <= '0;
      mask_reg   <= '0;
      mode_reg   <= mode_word_pkg::MODE_NONE;
      freq_reg   <= '0;
      volt_reg   <= '0;
      start_reg  <= 1'b0;
      stop_reg   <= 1'b0;
      off_reg    <= 1'b0;
    end else begin
      status_reg <= status_next;
      mask_reg   <= forced;
      mode_reg   <= mode_next;
      freq_reg   <= freq_ref;
      volt_reg   <= volt_ref;
      start_reg  <= local_reg && panel_start_i && !panel_stop_i;  // [R19]
      stop_reg   <= panel_stop_i || handover_stop;  // [R19] [R21]
      off_reg    <= panel_stop_i && hold_full && !off_done_reg && breaker_by_app_i;  // [R20]
    end
  end

  assign status_word_o  = status_reg;
  assign forced_mask_o  = mask_reg;
  assign mode_o         = mode_reg;
  assign freq_ref_o     = freq_reg;
  assign volt_ref_o     = volt_reg;
  assign local_active_o = local_reg;
  assign place_o        = place_reg;
  assign start_cmd_o    = start_reg;
  assign stop_cmd_o     = stop_reg;
  assign switch_off_o   = off_reg;

  property p_aci_top;
    @(posedge clock_i) disable iff (!rst_n_i)
      force_reg[`FW_ACI_BIT] |=> mode_reg == mode_word_pkg::MODE_ACI;
  endproperty
  a_aci_top: assert property (p_aci_top) else $error("AC mode not chosen"); // [R07] [R08]

  property p_dcv_over_isl;
    @(posedge clock_i) disable iff (!rst_n_i)
      (forced[6:4] == 3'b001) |=> mode_reg == mode_word_pkg::MODE_DCV;
  endproperty
  a_dcv_over_isl: assert property (p_dcv_over_isl) else $error("DC voltage priority"); // [R01] [R08]

  property p_fpw_only;
    @(posedge clock_i) disable iff (!rst_n_i)
      (forced == 7'h01) |=> mode_reg == mode_word_pkg::MODE_FPW;
  endproperty
  a_fpw_only: assert property (p_fpw_only) else $error("fixed power mode lost"); // [R05]

  property p_none;
    @(posedge clock_i) disable iff (!rst_n_i)
      (forced == 7'h00) |=> mode_reg == mode_word_pkg::MODE_NONE;
  endproperty
  a_none: assert property (p_none) else $error("mode forced without bit"); // [R08]

  property p_status_pick;
    @(posedge clock_i) disable iff (!rst_n_i)
      (sel_reg[0] == 7'h00) |=> status_word_o[0] == $past(mode_status_i[0]);
  endproperty
  a_status_pick: assert property (p_status_pick) else $error("status bit 0 wrong"); // [R16]

  property p_unused_zero;
    @(posedge clock_i) disable iff (!rst_n_i)
      (sel_reg[15] == `SEL_UNUSED) |=> !status_word_o[15];
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit nonzero"); // [R23]

  sequence s_stop_pressed;
    panel_stop_i;
  endsequence
  property p_stop_any_place;
    @(posedge clock_i) disable iff (!rst_n_i)
      s_stop_pressed |=> stop_cmd_o;
  endproperty
  a_stop_any_place: assert property (p_stop_any_place) else $error("stop ignored"); // [R19]

  property p_local_toggle;
    @(posedge clock_i) disable iff (!rst_n_i)
      remloc_rise |=> local_reg != $past(local_reg);
  endproperty
  a_local_toggle: assert property (p_local_toggle) else $error("local not toggled"); // [R18]

  property p_offcount;
    @(posedge clock_i) disable iff (!rst_n_i)
      switch_off_o |-> $past(hold_cnt_reg) == 32'(HOLD_CYCLES - 1);
  endproperty
  a_offcount: assert property (p_offcount) else $error("switch-off early"); // [R20]

  property p_handover;
    @(posedge clock_i) disable iff (!rst_n_i)
      (place_change && running_i && new_stop) |=> stop_cmd_o;
  endproperty
  a_handover: assert property (p_handover) else $error("handover did not stop"); // [R21] [R22]

  property p_freq_nominal;
    @(posedge clock_i) disable iff (!rst_n_i)
      (force_reg[`FW_FRS_BIT] && !force_reg[`FW_FSEL_BIT])
        |=> freq_ref == $past(freq_nominal_i);
  endproperty
  a_freq_nominal: assert property (p_freq_nominal) else $error("nominal freq lost"); // [R12]

  property p_volt_actual;
    @(posedge clock_i) disable iff (!rst_n_i)
      (force_reg[`FW_VRS_BIT] && force_reg[`FW_VSEL_BIT])
        |=> volt_ref == $past(volt_actual_i);
  endproperty
  a_volt_actual: assert property (p_volt_actual) else $error("actual volt lost"); // [R14]

  property p_off_single;
    @(posedge clock_i) disable iff (!rst_n_i)
      switch_off_o |=> !switch_off_o;
  endproperty
  a_off_single: assert property (p_off_single) else $error("switch-off repeated"); // [R20]

  property p_no_remote_start;
    @(posedge clock_i) disable iff (!rst_n_i)
      !local_reg |=> !start_cmd_o;
  endproperty
  a_no_remote_start: assert property (p_no_remote_start) else $error("remote panel start"); // [R19]
endmodule // mode_word_decoder

// >>> dv/fieldbus_master.sv
`timescale 1ns/1ns
module fieldbus_master (
  input  wire logic        clock_i,
  output logic             force_wr_o,
  output logic [15:0]      force_data_o
);
  initial begin
    force_wr_o   = 1'b0;
    force_data_o = 16'h0000;
  end
  // One write pulse, data scrambled once released
  task automatic send(input logic [15:0] word);
    @(posedge clock_i);
    force_wr_o   <= 1'b1;
    force_data_o <= word;
    @(posedge clock_i);
    force_wr_o   <= 1'b0;
    force_data_o <= ~word;
  endtask
endmodule // fieldbus_master

// >>> dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        force_wr_i, sel_wr_i = 1'b0, running_i = 1'b0;
  logic [15:0] force_data_i, force_word_o, status_word_o;
  logic [3:0]  sel_index_i = 4'h0, continue_en_i = 4'h0;
  logic [6:0]  sel_data_i = 7'h00, forced_mask_o;
  logic [15:0] mode_status_i = 16'h0000, app_status1_i = 16'h0000;
  logic [15:0] app_status2_i = 16'h0000, limit_status_i = 16'h0000;
  logic [15:0] freq_nominal_i = 16'h0064, freq_actual_i = 16'h00c8;
  logic [15:0] volt_nominal_i = 16'h012c, volt_actual_i = 16'h0190;
  logic [15:0] ref_step_i = 16'h0001, freq_ref_o, volt_ref_o, f, v;
  logic        panel_remloc_i = 1'b0, panel_start_i = 1'b0, panel_stop_i = 1'b0;
  logic        new_start_level_i = 1'b0, new_stop_req_i = 1'b0, breaker_by_app_i = 1'b0;
  logic        local_active_o, start_cmd_o, stop_cmd_o, switch_off_o;
  mode_word_pkg::mode_type       mode_o;
  mode_word_pkg::place_type      place_o;
  mode_word_pkg::place_type      place_req_i = mode_word_pkg::PLACE_IO;
  mode_word_pkg::start_mode_type new_start_mode_i = mode_word_pkg::START_PULSE;
  int          bad_count = 0;
  int          num_checks = 0;
  int          cycles = 0;

  initial forever #5 clock_i = ~clock_i;

  fieldbus_master master (.clock_i, .force_wr_o(force_wr_i), .force_data_o(force_data_i));

  mode_word_decoder #(.HOLD_CYCLES(20), .STEP_DIV(4)) dut (
    .clock_i, .rst_n_i, .force_wr_i, .force_data_i, .force_word_o, .sel_wr_i,
    .sel_index_i, .sel_data_i, .mode_status_i, .app_status1_i, .app_status2_i,
    .limit_status_i, .status_word_o, .forced_mask_o, .mode_o, .freq_nominal_i,
    .freq_actual_i, .volt_nominal_i, .volt_actual_i, .ref_step_i, .freq_ref_o,
    .volt_ref_o, .panel_remloc_i, .panel_start_i, .panel_stop_i, .place_req_i,
    .continue_en_i, .new_start_mode_i, .new_start_level_i, .new_stop_req_i,
    .running_i, .breaker_by_app_i, .local_active_o, .place_o, .start_cmd_o,
    .stop_cmd_o, .switch_off_o);

  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic mode_case(input logic [15:0] word, input logic [2:0] exp);
    logic [6:0] m;
    m = {word[6:5], word[0], word[1], word[2], word[3], word[4]};
    master.send(word);
    step(2);
    check("readback", word, force_word_o);
    check("mask", {9'h000, m}, {9'h000, forced_mask_o});
    check("mode", {13'h0000, exp}, {13'h0000, mode_o});
  endtask

  task automatic test_modes();
    mode_case(16'h0001, 3'h5);
    mode_case(16'h0002, 3'h4);
    mode_case(16'h0004, 3'h3);
    mode_case(16'h0008, 3'h2);
    mode_case(16'h0010, 3'h1);
    mode_case(16'h0020, 3'h6);
    mode_case(16'h0040, 3'h7);
    mode_case(16'h807f, 3'h7);
    mode_case(16'h0036, 3'h6);
    mode_case(16'h0016, 3'h4);
    mode_case(16'h001c, 3'h3);
    mode_case(16'h0018, 3'h2);
    mode_case(16'h8000, 3'h0);
    $display("test modes done");
  endtask

  task automatic test_refs();
    master.send(16'h1200);
    step(4);
    check("freq nominal", 16'h0064, freq_ref_o);
    check("volt nominal", 16'h012c, volt_ref_o);
    @(posedge clock_i);
    freq_actual_i <= 16'h00d2;
    volt_actual_i <= 16'h01a4;
    ref_step_i    <= 16'h0003;
    master.send(16'h7200);
    step(4);
    check("freq actual", 16'h00d2, freq_ref_o);
    check("volt actual", 16'h01a4, volt_ref_o);
    master.send(16'h0480);
    step(20);
    check("freq up", 16'h0001, {15'h0000, freq_ref_o > 16'h00d2});
    check("volt up", 16'h0001, {15'h0000, volt_ref_o > 16'h01a4});
    check("up in step", freq_ref_o - 16'h00d2, volt_ref_o - 16'h01a4);
    check("step size", 16'h0000, (freq_ref_o - 16'h00d2) % 16'h0003);
    master.send(16'h0d80);
    step(3);
    f = freq_ref_o;
    v = volt_ref_o;
    step(16);
    check("freq hold", f, freq_ref_o);
    check("volt hold", v, volt_ref_o);
    master.send(16'h0900);
    step(20);
    check("freq down", 16'h0001, {15'h0000, freq_ref_o < f});
    check("volt down", 16'h0001, {15'h0000, volt_ref_o < v});
    @(posedge clock_i);
    freq_nominal_i <= 16'h0032;
    volt_nominal_i <= 16'h0159;
    master.send(16'h1680);
    step(16);
    check("freq reset wins", 16'h0032, freq_ref_o);
    check("volt reset wins", 16'h0159, volt_ref_o);
    master.send(16'h0000);
    $display("test refs done");
  endtask

  task automatic sel_write(input logic [3:0] idx, input logic [6:0] code);
    @(posedge clock_i);
    sel_wr_i    <= 1'b1;
    sel_index_i <= idx;
    sel_data_i  <= code;
    @(posedge clock_i);
    sel_wr_i    <= 1'b0;
  endtask

  task automatic test_status();
    @(posedge clock_i);
    mode_status_i <= 16'h0015;
    app_status2_i <= 16'h0402;
    step(2);
    check("status default", 16'h00b5, status_word_o);
    sel_write(4'h8, 7'h13);
    sel_write(4'h9, 7'h3f);
    sel_write(4'h0, 7'h7f);
    app_status1_i  <= 16'h0008;
    limit_status_i <= 16'h8000;
    step(2);
    check("status custom", 16'h03b4, status_word_o);
    $display("test status done");
  endtask

  task automatic press_remloc();
    @(posedge clock_i) panel_remloc_i <= 1'b1;
    step(3);
    @(posedge clock_i) panel_remloc_i <= 1'b0;
    step(3);
  endtask

  task automatic hold_stop(input logic by_app, input logic [15:0] exp);
    int cnt;
    cnt = 0;
    @(posedge clock_i);
    breaker_by_app_i <= by_app;
    panel_stop_i     <= 1'b1;
    repeat (30) begin
      step(1);
      cnt += int'(switch_off_o);
    end
    @(posedge clock_i) panel_stop_i <= 1'b0;
    step(3);
    check("switch off pulses", exp, cnt[15:0]);
  endtask

  task automatic test_panel();
    @(posedge clock_i) panel_start_i <= 1'b1;
    step(3);
    check("start remote", 16'h0000, {15'h0000, start_cmd_o});
    press_remloc();
    check("local on", 16'h0001, {15'h0000, local_active_o});
    check("place local", {14'h0000, mode_word_pkg::PLACE_LOCAL}, {14'h0000, place_o});
    check("start local", 16'h0001, {15'h0000, start_cmd_o});
    @(posedge clock_i) panel_start_i <= 1'b0;
    press_remloc();
    check("local off", 16'h0000, {15'h0000, local_active_o});
    @(posedge clock_i) panel_stop_i <= 1'b1;
    step(2);
    check("stop remote", 16'h0001, {15'h0000, stop_cmd_o});
    @(posedge clock_i) panel_stop_i <= 1'b0;
    step(3);
    hold_stop(1'b1, 16'h0001);
    hold_stop(1'b0, 16'h0000);
    $display("test panel done");
  endtask

  task automatic hand(input logic [3:0] cont, input mode_word_pkg::start_mode_type sm,
                      input logic lvl, input logic stp, input logic exp);
    logic seen;
    seen = 1'b0;
    @(posedge clock_i);
    continue_en_i     <= cont;
    new_start_mode_i  <= sm;
    new_start_level_i <= lvl;
    new_stop_req_i    <= stp;
    running_i         <= 1'b1;
    step(4);
    @(posedge clock_i) place_req_i <= mode_word_pkg::PLACE_FBUS;
    repeat (6) begin
      step(1);
      seen |= stop_cmd_o;
    end
    check("handover stop", {15'h0000, exp}, {15'h0000, seen});
    @(posedge clock_i) running_i <= 1'b0;
    step(2);
    @(posedge clock_i) place_req_i <= mode_word_pkg::PLACE_IO;
    step(6);
  endtask

  task automatic test_handover();
    hand(4'h0, mode_word_pkg::START_PULSE, 1'b1, 1'b0, 1'b1);
    hand(4'hf, mode_word_pkg::START_PULSE, 1'b1, 1'b0, 1'b0);
    hand(4'hf, mode_word_pkg::START_PULSE, 1'b1, 1'b1, 1'b1);
    hand(4'hf, mode_word_pkg::START_LEVEL, 1'b0, 1'b0, 1'b1);
    hand(4'hf, mode_word_pkg::START_EDGE, 1'b0, 1'b0, 1'b1);
    hand(4'hf, mode_word_pkg::START_LEVEL, 1'b1, 1'b0, 1'b0);
    $display("test handover done");
  endtask

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      close_out();
    end
  end

  initial begin
    step(20);
    rst_n_i <= 1'b1;
    step(1);
    test_modes();
    test_refs();
    test_status();
    test_panel();
    test_handover();
    close_out();
  end
endmodule // tb_top
